// >>> verilog/bqf_pkg.sv
// Package: register map, field positions and sizes for the byte queue
package bqf_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int QUEUE_DEPTH = 64;
    localparam int ADDR_W = 6;
    localparam logic [6:0] QUEUE_FULL_COUNT = 7'h40;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [5:0] OFS_QUEUE_DATA = 6'h02;
    localparam logic [5:0] OFS_PRIMARY_FLAGS = 6'h03;
    localparam logic [5:0] OFS_FILL_COUNT = 6'h04;
    localparam logic [5:0] OFS_IRQ_ENABLE = 6'h06;
    localparam logic [5:0] OFS_IRQ_REQUEST = 6'h07;
    localparam logic [5:0] OFS_CONTROL = 6'h09;
    localparam logic [5:0] OFS_ERROR_FLAGS = 6'h0A;
    localparam logic [5:0] OFS_THRESHOLD = 6'h29;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_NEARLY_EMPTY = 0;
    localparam int BIT_NEARLY_FULL = 1;
    localparam int BIT_IRQ_ANY = 3;
    localparam int BIT_FLUSH = 0;
    localparam int BIT_OVERFLOW = 4;
    localparam int BIT_SET_SELECT = 7;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [5:0] RST_THRESHOLD = 6'h08;
    localparam logic [1:0] RST_IRQ = 2'h0;
endpackage : bqf_pkg

// >>> verilog/bqf_byte_queue.sv
// Module: 64 x 8 byte queue with fill count, overflow and threshold warnings
`timescale 1ns/10ps

// Summary of operation
// - One 64-entry by 8-bit queue shared by host and command engine.
// - Host data-port write stores byte at write pointer, then advances it.
// - Host data-port read returns byte at read pointer, then advances it.
// - Fill-count register reports stored bytes, 7 bits wide.
// - Flush resets both pointers, zeroes count and clears overflow.
// - Write while full sets overflow; only flush clears it.
// - Nearly-full warning when 64 minus fill count is at most threshold.
// - Nearly-empty warning when fill count is at most the 6-bit threshold.
// - Enabled warning rising edge sets its request and raises interrupt.
// - Nearly-full at bit 1, nearly-empty at bit 0, same for enable/request.
// - Interrupt flag and line are OR of enabled request flags.
// - Top bit of enable/request write selects set or clear of ones.
module bqf_byte_queue (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic eng_push,
    input wire logic [7:0] eng_push_data,
    input wire logic eng_pop,
    output logic [7:0] eng_pop_data,
    output logic queue_full,
    output logic queue_empty,
    output logic irq
);

    // ------------------------------------------------------------
    // Storage and pointers
    // ------------------------------------------------------------
    logic [7:0] mem [bqf_pkg::QUEUE_DEPTH];
    logic [5:0] wr_ptr;
    logic [5:0] rd_ptr;
    logic [6:0] fill_count;
    logic overflow_error;
    logic [5:0] warning_threshold;
    logic [1:0] irq_enable_mask;
    logic [1:0] irq_request_flags;
    logic [1:0] warn_prev;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire host_wr_data = reg_wr && (reg_addr == bqf_pkg::OFS_QUEUE_DATA);
    wire host_rd_data = reg_rd && (reg_addr == bqf_pkg::OFS_QUEUE_DATA);
    wire wr_en_reg = reg_wr && (reg_addr == bqf_pkg::OFS_IRQ_ENABLE);
    wire wr_req_reg = reg_wr && (reg_addr == bqf_pkg::OFS_IRQ_REQUEST);
    wire wr_ctrl = reg_wr && (reg_addr == bqf_pkg::OFS_CONTROL);
    wire wr_thr = reg_wr && (reg_addr == bqf_pkg::OFS_THRESHOLD);
    wire flush = wr_ctrl && reg_wdata[bqf_pkg::BIT_FLUSH];
    // Host and engine share one port each; host wins a same-cycle clash
    wire push_req = host_wr_data || eng_push;
    wire pop_req = host_rd_data || eng_pop;
    wire [7:0] push_data = host_wr_data ? reg_wdata : eng_push_data;
    wire is_full = (fill_count == bqf_pkg::QUEUE_FULL_COUNT);
    wire is_empty = (fill_count == 7'h00);
    wire do_push = push_req && !is_full && !flush;
    wire do_pop = pop_req && !is_empty && !flush;
    wire push_overflow = push_req && is_full && !flush;

    // ------------------------------------------------------------
    // Warnings
    // ------------------------------------------------------------
    wire [6:0] free_space = bqf_pkg::QUEUE_FULL_COUNT - fill_count;
    wire nearly_full_warning = free_space <= {1'b0, warning_threshold};
    wire nearly_empty_warning = fill_count <= {1'b0, warning_threshold};
    wire [1:0] warn_now = {nearly_full_warning, nearly_empty_warning};
    wire [1:0] warn_rise = warn_now & ~warn_prev;
    wire [1:0] sw_req_set = wr_req_reg && reg_wdata[bqf_pkg::BIT_SET_SELECT]
                            ? reg_wdata[1:0] : 2'h0;
    wire [1:0] sw_req_clr = wr_req_reg && !reg_wdata[bqf_pkg::BIT_SET_SELECT]
                            ? reg_wdata[1:0] : 2'h0;
    // Hardware set beats a same-cycle software clear
    wire [1:0] next_req = (irq_request_flags & ~sw_req_clr) | sw_req_set
                          | (warn_rise & irq_enable_mask);
    wire [1:0] next_en = wr_en_reg
                         ? (reg_wdata[bqf_pkg::BIT_SET_SELECT]
                            ? (irq_enable_mask | reg_wdata[1:0])
                            : (irq_enable_mask & ~reg_wdata[1:0]))
                         : irq_enable_mask;
    wire irq_any = |(irq_request_flags & irq_enable_mask);

    // ------------------------------------------------------------
    // Queue storage
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (do_push)
        begin
            mem[wr_ptr] <= push_data;
        end
    end

    // ------------------------------------------------------------
    // Pointers, count, overflow
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || flush)
        begin
            wr_ptr <= 6'h00;
            rd_ptr <= 6'h00;
            fill_count <= 7'h00;
        end
        else
        begin
            if (do_push)
            begin
                wr_ptr <= wr_ptr + 6'h01;
            end
            if (do_pop)
            begin
                rd_ptr <= rd_ptr + 6'h01;
            end
            fill_count <= fill_count + {6'h00, do_push} - {6'h00, do_pop};
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || flush)
        begin
            overflow_error <= 1'b0;
        end
        else if (push_overflow)
        begin
            overflow_error <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Threshold and interrupt registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            warning_threshold <= bqf_pkg::RST_THRESHOLD;
            irq_enable_mask <= bqf_pkg::RST_IRQ;
            irq_request_flags <= bqf_pkg::RST_IRQ;
            warn_prev <= 2'h3;
        end
        else
        begin
            if (wr_thr)
            begin
                warning_threshold <= reg_wdata[5:0];
            end
            irq_enable_mask <= next_en;
            irq_request_flags <= next_req;
            warn_prev <= warn_now;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    wire [7:0] primary_flags = {4'h0, irq_any, 1'b0, warn_now};
    wire [7:0] error_flags = {3'h0, overflow_error, 4'h0};
    wire [7:0] rd_mux =
        (reg_addr == bqf_pkg::OFS_QUEUE_DATA) ? (is_empty ? 8'h00 : mem[rd_ptr]) :
        (reg_addr == bqf_pkg::OFS_PRIMARY_FLAGS) ? primary_flags :
        (reg_addr == bqf_pkg::OFS_FILL_COUNT) ? {1'b0, fill_count} :
        (reg_addr == bqf_pkg::OFS_IRQ_ENABLE) ? {6'h00, irq_enable_mask} :
        (reg_addr == bqf_pkg::OFS_IRQ_REQUEST) ? {6'h00, irq_request_flags} :
        (reg_addr == bqf_pkg::OFS_ERROR_FLAGS) ? error_flags :
        (reg_addr == bqf_pkg::OFS_THRESHOLD) ? {2'h0, warning_threshold} :
        8'h00;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            reg_rdata <= 8'h00;
            eng_pop_data <= 8'h00;
            irq <= 1'b0;
        end
        else
        begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
            if (eng_pop && !host_rd_data && !is_empty)
            begin
                eng_pop_data <= mem[rd_ptr];
            end
            irq <= |(next_req & next_en);
        end
    end

    // Engine sees the shared state; clash avoidance is software's job
    assign queue_full = is_full;
    assign queue_empty = is_empty;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_push_advances: assert property (@(posedge clk_sys) disable iff (!rst_n)
        do_push |=> wr_ptr == $past(wr_ptr) + 6'h01)
        else $error("write pointer did not advance");
    a_pop_advances: assert property (@(posedge clk_sys) disable iff (!rst_n)
        do_pop |=> rd_ptr == $past(rd_ptr) + 6'h01)
        else $error("read pointer did not advance");
    a_count_matches: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (fill_count <= 7'h40) && (fill_count[5:0] == wr_ptr - rd_ptr))
        else $error("fill count disagrees with pointers");
    a_flush_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
        flush |=> fill_count == 7'h00 && !overflow_error)
        else $error("flush did not empty queue");
    a_overflow_sets: assert property (@(posedge clk_sys) disable iff (!rst_n)
        push_overflow |=> overflow_error)
        else $error("overflow not flagged");
    a_overflow_sticks: assert property (@(posedge clk_sys) disable iff (!rst_n)
        overflow_error && !flush |=> overflow_error)
        else $error("overflow cleared without flush");
    a_full_no_store: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_full && !pop_req && !flush |=> $stable(wr_ptr))
        else $error("write pointer moved while full");
    a_warn_irq: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (warn_rise[1] && irq_enable_mask[1]) |=> irq_request_flags[1] && irq)
        else $error("nearly-full rise did not raise interrupt");
    a_irq_or: assert property (@(posedge clk_sys) disable iff (!rst_n)
        irq == irq_any)
        else $error("interrupt line mismatch");
    c_fill_full: cover property (@(posedge clk_sys) disable iff (!rst_n) is_full);
    c_overflow: cover property (@(posedge clk_sys) disable iff (!rst_n) push_overflow);
    c_irq: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(irq));
    c_empty_irq: cover property (@(posedge clk_sys) disable iff (!rst_n) warn_rise[0]);
    c_flush_busy: cover property (@(posedge clk_sys) disable iff (!rst_n) flush && !is_empty);

    // ------------------------------------------------------------
    // Pointer, count, storage and overflow checks
    // ------------------------------------------------------------
    a_empty_no_pop: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_empty && !flush |=> $stable(rd_ptr))
        else $error("read pointer moved while empty");
    a_full_keeps: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_full && !pop_req && !flush |=> fill_count == 7'h40)
        else $error("full queue count changed");
    a_push_stores: assert property (@(posedge clk_sys) disable iff (!rst_n)
        do_push |=> mem[$past(wr_ptr)] == $past(push_data))
        else $error("pushed byte not stored");
    a_count_up: assert property (@(posedge clk_sys) disable iff (!rst_n)
        do_push && !do_pop |=> fill_count == $past(fill_count) + 7'h01)
        else $error("count did not rise on push");
    a_count_down: assert property (@(posedge clk_sys) disable iff (!rst_n)
        do_pop && !do_push |=> fill_count == $past(fill_count) - 7'h01)
        else $error("count did not fall on pop");
    a_flush_ptrs: assert property (@(posedge clk_sys) disable iff (!rst_n)
        flush |=> wr_ptr == 6'h00 && rd_ptr == 6'h00)
        else $error("flush left pointers set");
    a_overflow_cause: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !overflow_error && !push_overflow |=> !overflow_error)
        else $error("overflow set without full write");

    // ------------------------------------------------------------
    // Warning checks
    // ------------------------------------------------------------
    a_full_warns: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_full |-> nearly_full_warning)
        else $error("full queue without nearly-full warning");
    a_empty_warns: assert property (@(posedge clk_sys) disable iff (!rst_n)
        is_empty |-> nearly_empty_warning)
        else $error("empty queue without nearly-empty warning");
    a_nf_zero_thr: assert property (@(posedge clk_sys) disable iff (!rst_n)
        warning_threshold == 6'h00 && !is_full |-> !nearly_full_warning)
        else $error("nearly-full with free space at zero threshold");
    a_ne_zero_thr: assert property (@(posedge clk_sys) disable iff (!rst_n)
        warning_threshold == 6'h00 && !is_empty |-> !nearly_empty_warning)
        else $error("nearly-empty with data at zero threshold");

    // ------------------------------------------------------------
    // Interrupt register and read data checks
    // ------------------------------------------------------------
    a_ne_irq_req: assert property (@(posedge clk_sys) disable iff (!rst_n)
        warn_rise[0] && irq_enable_mask[0] |=> irq_request_flags[0])
        else $error("nearly-empty rise did not set request");
    a_nf_no_stray: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !irq_request_flags[1] && !(warn_rise[1] && irq_enable_mask[1])
        && !(wr_req_reg && reg_wdata[7] && reg_wdata[1]) |=> !irq_request_flags[1])
        else $error("nearly-full request set without cause");
    a_ne_no_stray: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !irq_request_flags[0] && !(warn_rise[0] && irq_enable_mask[0])
        && !(wr_req_reg && reg_wdata[7] && reg_wdata[0]) |=> !irq_request_flags[0])
        else $error("nearly-empty request set without cause");
    a_req_sw_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_req_reg && reg_wdata[7] && reg_wdata[0] |=> irq_request_flags[0])
        else $error("request set write ignored");
    a_req_sw_clr: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_req_reg && !reg_wdata[7] && reg_wdata[0] && !warn_rise[0]
        |=> !irq_request_flags[0])
        else $error("request clear write ignored");
    a_req_keep: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_req_reg && !reg_wdata[1] && !warn_rise[1]
        |=> irq_request_flags[1] == $past(irq_request_flags[1]))
        else $error("unselected request bit changed");
    a_en_sw_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_en_reg && reg_wdata[7] && reg_wdata[1] |=> irq_enable_mask[1])
        else $error("enable set write ignored");
    a_en_sw_clr: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_en_reg && !reg_wdata[7] && reg_wdata[1] |=> !irq_enable_mask[1])
        else $error("enable clear write ignored");
    a_en_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !wr_en_reg |=> $stable(irq_enable_mask))
        else $error("enable mask changed without write");
    a_rdata_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not idle after no read");

endmodule : bqf_byte_queue

// >>> verif/bqf_engine_model.sv
// Command engine stand-in that pushes and pops queue bytes on request
`timescale 1ns/10ps
module bqf_engine_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cmd_push,
    input wire logic cmd_pop,
    input wire logic [7:0] cmd_data,
    output logic eng_push,
    output logic [7:0] eng_push_data,
    output logic eng_pop
);
    // Bench schedules requests away from host cycles: one shared queue
    always_ff @(posedge clk_sys)
    begin
        eng_push <= rst_n & cmd_push;
        eng_pop <= rst_n & cmd_pop;
        // Idle data toggles so a stale byte never looks valid
        eng_push_data <= !rst_n ? 8'h00 : (cmd_push ? cmd_data : ~eng_push_data);
    end
endmodule : bqf_engine_model

// >>> verif/tb_top.sv
// Self-checking bench for the byte queue
`timescale 1ns/10ps
module tb_top;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] reg_addr = 6'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic cmd_push = 1'b0;
    logic cmd_pop = 1'b0;
    logic [7:0] cmd_data = 8'h00;
    logic eng_push, eng_pop, queue_full, queue_empty, irq;
    logic [7:0] reg_rdata, eng_push_data, eng_pop_data, rd_val;
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    always #50 clk_sys = ~clk_sys;
    bqf_byte_queue u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .eng_push(eng_push), .eng_push_data(eng_push_data), .eng_pop(eng_pop),
        .eng_pop_data(eng_pop_data), .queue_full(queue_full), .queue_empty(queue_empty),
        .irq(irq));
    bqf_engine_model u_eng (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_push(cmd_push),
        .cmd_pop(cmd_pop), .cmd_data(cmd_data), .eng_push(eng_push),
        .eng_push_data(eng_push_data), .eng_pop(eng_pop));
    // ------------------------------------------------------------
    // Bus and check helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [5:0] a, input logic [7:0] m);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        rd_val = reg_rdata & m;
    endtask : rd
    task automatic eng(input logic push, input logic [7:0] d);
        @(posedge clk_sys);
        cmd_push <= push;
        cmd_pop <= !push;
        cmd_data <= d;
        @(posedge clk_sys);
        cmd_push <= 1'b0;
        cmd_pop <= 1'b0;
        @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : eng
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk("flags reset", 8'h01, {6'h00, queue_full, queue_empty});
        rd(bqf_pkg::OFS_THRESHOLD, 8'h3F);
        chk("threshold", 8'h08, rd_val);
        @(negedge clk_sys);
        chk("rdata idle", 8'h00, reg_rdata);
        rd(bqf_pkg::OFS_QUEUE_DATA, 8'hFF);
        chk("empty read", 8'h00, rd_val);
        rd(bqf_pkg::OFS_FILL_COUNT, 8'hFF);
        chk("count", 8'h00, rd_val);
    endtask : t_reset
    task automatic t_thresh();
        wr(bqf_pkg::OFS_THRESHOLD, 8'h00);
        rd(bqf_pkg::OFS_THRESHOLD, 8'h3F);
        chk("threshold set", 8'h00, rd_val);
        rd(bqf_pkg::OFS_PRIMARY_FLAGS, 8'h0B);
        chk("warn none", 8'h08, rd_val);
        wr(bqf_pkg::OFS_IRQ_ENABLE, 8'h02);
        rd(bqf_pkg::OFS_IRQ_ENABLE, 8'h03);
        chk("enable clear", 8'h01, rd_val);
        wr(bqf_pkg::OFS_CONTROL, 8'h01);
        rd(bqf_pkg::OFS_PRIMARY_FLAGS, 8'h0B);
        chk("warn flushed", 8'h09, rd_val);
        chk("empty pin", 8'h01, {7'h00, queue_empty});
    endtask : t_thresh
    task automatic t_fill();
        for (int i = 0; i < 64; i++)
            wr(bqf_pkg::OFS_QUEUE_DATA, 8'(i + 8'h30));
        rd(bqf_pkg::OFS_FILL_COUNT, 8'hFF);
        chk("count full", 8'h40, rd_val);
        chk("full", 8'h01, {7'h00, queue_full});
        wr(bqf_pkg::OFS_QUEUE_DATA, 8'hEE);
        rd(bqf_pkg::OFS_FILL_COUNT, 8'hFF);
        chk("count ovf", 8'h40, rd_val);
        rd(bqf_pkg::OFS_QUEUE_DATA, 8'hFF);
        chk("first byte", 8'h30, rd_val);
        rd(bqf_pkg::OFS_ERROR_FLAGS, 8'h10);
        chk("overflow", 8'h10, rd_val);
        rd(bqf_pkg::OFS_FILL_COUNT, 8'hFF);
        chk("count read", 8'h3F, rd_val);
        wr(bqf_pkg::OFS_CONTROL, 8'h01);
        rd(bqf_pkg::OFS_FILL_COUNT, 8'hFF);
        chk("count flush", 8'h00, rd_val);
        rd(bqf_pkg::OFS_ERROR_FLAGS, 8'h10);
        chk("overflow flush", 8'h00, rd_val);
    endtask : t_fill
    task automatic t_warn();
        wr(bqf_pkg::OFS_IRQ_ENABLE, 8'h83);
        eng(1'b1, 8'hA5);
        for (int i = 0; i < 55; i++)
            wr(bqf_pkg::OFS_QUEUE_DATA, 8'(i));
        rd(bqf_pkg::OFS_PRIMARY_FLAGS, 8'h0B);
        chk("warn full", 8'h0A, rd_val);
        rd(bqf_pkg::OFS_IRQ_REQUEST, 8'h03);
        chk("req full", 8'h02, rd_val);
        chk("irq set", 8'h01, {7'h00, irq});
        wr(bqf_pkg::OFS_IRQ_REQUEST, 8'h02);
        rd(bqf_pkg::OFS_IRQ_REQUEST, 8'h03);
        chk("req clear", 8'h00, rd_val);
        chk("irq clear", 8'h00, {7'h00, irq});
        wr(bqf_pkg::OFS_IRQ_REQUEST, 8'h81);
        rd(bqf_pkg::OFS_IRQ_REQUEST, 8'h03);
        chk("req set", 8'h01, rd_val);
        wr(bqf_pkg::OFS_IRQ_REQUEST, 8'h3F);
        eng(1'b0, 8'h00);
        chk("pop engine byte", 8'hA5, eng_pop_data);
        eng(1'b0, 8'h00);
        chk("pop host byte", 8'h00, eng_pop_data);
        for (int i = 0; i < 46; i++)
            eng(1'b0, 8'h00);
        rd(bqf_pkg::OFS_PRIMARY_FLAGS, 8'h03);
        chk("warn empty", 8'h01, rd_val);
        rd(bqf_pkg::OFS_IRQ_REQUEST, 8'h03);
        chk("req empty", 8'h01, rd_val);
        chk("irq empty", 8'h01, {7'h00, irq});
    endtask : t_warn
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test
    // Ceiling well above the roughly 465 cycles the sequence needs
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            err_total++;
            end_of_test();
        end
    end
    initial
    begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_fill();
        t_warn();
        t_thresh();
        end_of_test();
    end
endmodule : tb_top
